// ### usc_pkg.sv
package usc_pkg;

    // byte addresses on the register bus
    localparam logic [4:0] OFS_PSTAT = 5'h00; // primary_status
    localparam logic [4:0] OFS_STAT2 = 5'h04; // status_two
    localparam logic [4:0] OFS_CTRL3 = 5'h08; // control_three
    localparam logic [4:0] OFS_DATA  = 5'h0C; // data_window
    localparam logic [4:0] OFS_CTRL1 = 5'h10; // mode and enables
    localparam logic [4:0] OFS_BAUD  = 5'h14; // 16x sample divider

    // mode and enable bits
    localparam int C1_NINE  = 0;
    localparam int C1_LOOP_SELECT = 1;
    localparam int C1_RECEIVER_SOURCE_SELECT  = 2;
    localparam int C1_TE    = 3;
    localparam int C1_RE    = 4;
    localparam int C1_SBK   = 5;
    localparam int C1_PE    = 6;
    localparam int C1_PODD  = 7;
    // primary_status bits
    localparam int S1_RECEIVE_FULL_FLAG  = 5;
    localparam int S1_OR    = 3;
    localparam int S1_PF    = 0;
    // status_two bits
    localparam int S2_LONG_BREAK_SELECT = 2;
    // control_three bits
    localparam int C3_T8    = 6;
    localparam int C3_DIR   = 5;
    localparam int C3_INV   = 4;
    localparam int C3_OVERRUN_IRQ_ENABLE  = 3;
    localparam int C3_PARITY_IRQ_ENABLE  = 0;
    // error flag vector, same order as the enables
    localparam int E_OR     = 3;
    localparam int E_NF     = 2;
    localparam int E_FE     = 1;
    localparam int E_PF     = 0;

    // bit counts and sample points (16 samples per bit)
    localparam logic [3:0] BRK_SHORT = 4'hA;
    localparam logic [3:0] BRK_LONG  = 4'hD;
    localparam logic [3:0] FRAME8    = 4'hA;
    localparam logic [3:0] DATA8     = 4'h8;
    localparam logic [3:0] TX_RT_END = 4'hF;
    localparam logic [3:0] RT_FIRST  = 4'h1;
    localparam logic [3:0] RT_END    = 4'h0;
    localparam logic [3:0] RT_S1     = 4'h3;
    localparam logic [3:0] RT_S2     = 4'h5;
    localparam logic [3:0] RT_VER    = 4'h7;
    localparam logic [3:0] RT_D1     = 4'h8;
    localparam logic [3:0] RT_D2     = 4'h9;
    localparam logic [3:0] RT_BIT    = 4'hA;
    localparam logic [3:0] RT_LATE   = 4'hB;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_DATA  = 2'b01,
        TX_BREAK = 2'b10
    } usc_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_FRAME = 2'b01
    } usc_rx_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } usc_bus_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [12:0] baud_cnt;
        logic [12:0] baud_div;
        logic [7:0]  c1;
        logic        long_break_select;
        logic        r8;
        logic        t8;
        logic        dir;
        logic        inv;
        logic [3:0]  ie;
        logic [7:0]  tx_buf;
        logic        tx_buf8;
        logic        tx_full;
        logic        tx_done;
        usc_tx_t     tx_st;
        logic [10:0] tx_sh;
        logic [3:0]  tx_bits;
        logic [3:0]  tx_rt;
        logic        tx_line;
        logic        tx_pin;
        logic        oe;
        usc_rx_t     rx_st;
        logic [2:0]  rx_hist;
        logic [2:0]  rx_smp;
        logic [3:0]  rx_rt;
        logic [3:0]  rx_idx;
        logic [8:0]  rx_sh;
        logic        rx_noise;
        logic [7:0]  rx_buf;
        logic        receive_full_flag;
        logic [3:0]  err;
        logic        receiver_active_flag;
        logic [7:0]  idle_cnt;
        logic        arm;
        logic        seen_data;
        logic        seen_c3;
        logic        irq;
    } usc_state_t;

    localparam usc_state_t ST_RESET = '{
        tx_line: 1'b1, tx_pin: 1'b1, tx_done: 1'b1,
        tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};

endpackage

// ### usc_core.sv
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - break is 10 or 13 bits, plus nine-bit
// - framing check ignores long break select
// - active flag set at start, cleared on idle
// - active flag is read-only
// - ninth received bit at bit 7, both reads
// - stored ninth tx bit goes with data
// - single-wire direction bit steers output pin
// - invert bit inverts every driven level
// - overrun flag with enable requests interrupt
// - noise flag with enable requests interrupt
// - framing flag with enable requests interrupt
// - parity flag with enable requests interrupt
// - data address reads rx, writes tx
// - data reads step flag clearing
// - tx and rx independent, shared baud
// - baud generator runs on bus clock
// - receiver realigns on falling edges inside a frame, after the start bit
// - full-duplex NRZ frames, same baud
// - nine-bit: status, data and ninth reads
// - overrun drops new character and status
module usc_core (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire usc_pkg::usc_bus_t avs,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              rxd_in,
    input  wire logic              txd_in,
    output logic                   txd_out,
    output logic                   txd_oe,
    output logic                   irq_req
);
    import usc_pkg::*;

    usc_state_t  q;
    usc_state_t  next_q;
    logic        tick;
    logic        req;
    logic        acc;
    logic        rx_pin;
    logic        rx_done;
    logic [31:0] rd_val;
    logic [3:0]  fbits;

    // majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // samples that disagree mark noise
    function automatic logic mixed3(input logic [2:0] s);
        return (s != 3'h0) && (s != 3'h7);
    endfunction

    // transmit frame, start bit in bit 0, parity folded in
    function automatic logic [10:0] frame(input logic [7:0] d,
                                          input logic       b8,
                                          input logic [7:0] c1);
        logic [7:0] dd;
        logic       b;
        dd = d;
        b  = c1[C1_NINE] ? b8 : 1'b1;
        if (c1[C1_PE] && c1[C1_NINE]) begin
            b = (^d) ^ c1[C1_PODD];
        end else if (c1[C1_PE]) begin
            dd[7] = (^d[6:0]) ^ c1[C1_PODD];
        end
        return {1'b1, b, dd, 1'b0};
    endfunction

    // data outputs straight from the state flops
    assign avs_readdata    = q.rdata;
    assign txd_out         = q.tx_pin;
    assign txd_oe          = q.oe;
    assign irq_req         = q.irq;
    assign req             = avs.read | avs.write;
    assign acc             = req & q.ack;
    assign avs_waitrequest = req & ~q.ack;
    assign fbits           = FRAME8 + {3'h0, q.c1[C1_NINE]};
    // one divider clocks both directions
    assign tick = (q.baud_div != 13'h0000) && (q.baud_cnt == 13'h0000);
    // loop feeds the transmitter back, single wire uses the pin
    assign rx_pin = q.c1[C1_LOOP_SELECT] ? (q.c1[C1_RECEIVER_SOURCE_SELECT] ? txd_in : q.tx_line)
                                   : rxd_in;

    // read mux, sampled one cycle before the answer edge
    always_comb begin
        case (avs.address)
            OFS_PSTAT: rd_val = {24'h0, ~q.tx_full, q.tx_done, q.receive_full_flag,
                                 1'b0, q.err};
            OFS_STAT2: rd_val = {29'h0, q.long_break_select, 1'b0, q.receiver_active_flag};
            OFS_CTRL3: rd_val = {24'h0, q.r8, q.t8, q.dir, q.inv, q.ie};
            OFS_DATA:  rd_val = {24'h0, q.rx_buf};
            OFS_CTRL1: rd_val = {24'h0, q.c1};
            OFS_BAUD:  rd_val = {19'h0, q.baud_div};
            default:   rd_val = 32'h0000_0000;
        endcase
    end

    // whole next-state function; order sets bus clears before rx sets
    always_comb begin
        logic [2:0] cur;
        logic       stop;
        logic       bad_par;
        logic [3:0] brk;
        cur     = {q.rx_smp[1:0], rx_pin};
        stop    = maj3(cur);
        bad_par = 1'b0;
        brk     = (q.long_break_select ? BRK_LONG : BRK_SHORT)
                  + {3'h0, q.c1[C1_NINE]};
        next_q  = q;
        rx_done = 1'b0;

        // baud divider, period of baud_div bus clocks
        if (q.baud_div != 13'h0000) begin
            next_q.baud_cnt = (q.baud_cnt == 13'h0000)
                              ? q.baud_div - 13'h0001
                              : q.baud_cnt - 13'h0001;
        end

        // transmitter, 16 ticks per bit
        if (tick) begin
            case (q.tx_st)
                TX_IDLE: begin
                    next_q.tx_rt = 4'h0;
                    if (q.c1[C1_TE] && q.c1[C1_SBK]) begin
                        next_q.tx_st   = TX_BREAK;
                        next_q.tx_bits = brk - 4'h1;
                        next_q.tx_done = 1'b0;
                    end else if (q.c1[C1_TE] && q.tx_full) begin
                        // ninth bit travels with the byte
                        next_q.tx_st   = TX_DATA;
                        next_q.tx_sh   = frame(q.tx_buf, q.tx_buf8, q.c1);
                        next_q.tx_bits = fbits - 4'h1;
                        next_q.tx_full = 1'b0;
                        next_q.tx_done = 1'b0;
                    end else begin
                        next_q.tx_done = 1'b1;
                    end
                end
                TX_DATA, TX_BREAK: begin
                    next_q.tx_rt = q.tx_rt + 4'h1;
                    if (q.tx_rt == TX_RT_END) begin
                        if (q.tx_bits == 4'h0) begin
                            next_q.tx_st = TX_IDLE;
                        end else begin
                            next_q.tx_bits = q.tx_bits - 4'h1;
                            next_q.tx_sh   = {1'b1, q.tx_sh[10:1]};
                        end
                    end
                end
                default: next_q.tx_st = TX_IDLE;
            endcase
        end
        // NRZ line level, idle high
        next_q.tx_line = (next_q.tx_st == TX_DATA) ? next_q.tx_sh[0]
                         : (next_q.tx_st != TX_BREAK);

        // register writes take effect at the answer edge
        if (acc && avs.write) begin
            case (avs.address)
                OFS_CTRL1: next_q.c1       = avs.writedata[7:0];
                OFS_BAUD:  next_q.baud_div = avs.writedata[12:0];
                // only the break length is writable here
                OFS_STAT2: next_q.long_break_select = avs.writedata[S2_LONG_BREAK_SELECT];
                OFS_CTRL3: begin
                    next_q.t8  = avs.writedata[C3_T8];
                    next_q.dir = avs.writedata[C3_DIR];
                    next_q.inv = avs.writedata[C3_INV];
                    next_q.ie  = avs.writedata[C3_OVERRUN_IRQ_ENABLE:C3_PARITY_IRQ_ENABLE];
                end
                OFS_DATA: begin
                    // separate tx buffer; the held ninth bit is sampled
                    // now, so it must be written first
                    next_q.tx_buf  = avs.writedata[7:0];
                    next_q.tx_buf8 = q.t8;
                    next_q.tx_full = 1'b1;
                end
                default: ;
            endcase
        end

        // read side effects: the clearing sequences
        if (acc && avs.read) begin
            case (avs.address)
                OFS_PSTAT: begin
                    next_q.arm = q.rdata[S1_RECEIVE_FULL_FLAG]
                                 | (|q.rdata[S1_OR:S1_PF]);
                    next_q.seen_data = 1'b0;
                    next_q.seen_c3   = 1'b0;
                end
                OFS_DATA: if (q.arm) begin
                    next_q.err       = 4'h0;
                    next_q.seen_data = 1'b1;
                end
                OFS_CTRL3: if (q.arm) begin
                    next_q.seen_c3 = 1'b1;
                end
                default: ;
            endcase
        end
        // nine-bit mode needs both reads in any order
        if (next_q.arm && next_q.seen_data
            && (next_q.seen_c3 || !q.c1[C1_NINE])) begin
            next_q.receive_full_flag = 1'b0;
            next_q.arm  = 1'b0;
        end

        // receiver, runs apart from the transmitter
        if (tick && q.c1[C1_RE]) begin
            next_q.rx_hist = {q.rx_hist[1:0], rx_pin};
            case (q.rx_st)
                RX_IDLE: begin
                    // a full character of high line ends activity
                    if (!rx_pin) begin
                        next_q.idle_cnt = 8'h00;
                    end else if (q.idle_cnt != {fbits, 4'h0}) begin
                        next_q.idle_cnt = q.idle_cnt + 8'h01;
                    end else begin
                        next_q.receiver_active_flag = 1'b0;
                    end
                    // start: a low after three high samples
                    if (q.rx_hist == 3'h7 && !rx_pin) begin
                        next_q.rx_st    = RX_FRAME;
                        next_q.rx_rt    = RT_FIRST;
                        next_q.rx_idx   = 4'h0;
                        next_q.rx_noise = 1'b0;
                    end
                end
                RX_FRAME: begin
                    next_q.rx_rt = q.rx_rt + 4'h1;
                    if ((q.rx_idx == 4'h0 && (q.rx_rt == RT_S1
                         || q.rx_rt == RT_S2 || q.rx_rt == RT_VER))
                        || (q.rx_idx != 4'h0 && (q.rx_rt == RT_D1
                         || q.rx_rt == RT_D2 || q.rx_rt == RT_BIT))) begin
                        next_q.rx_smp = cur;
                    end
                    if (q.rx_rt == RT_END) begin
                        next_q.rx_idx = q.rx_idx + 4'h1;
                    end
                    if (q.rx_idx == 4'h0 && q.rx_rt == RT_VER) begin
                        if (maj3(cur)) begin
                            next_q.rx_st = RX_IDLE; // false start
                        end else begin
                            next_q.receiver_active_flag      = 1'b1;
                            next_q.rx_noise = mixed3(cur);
                        end
                    end
                    if (q.rx_idx != 4'h0 && q.rx_rt == RT_BIT) begin
                        next_q.rx_noise = q.rx_noise | mixed3(cur);
                        if (q.rx_idx != DATA8 + {3'h0, q.c1[C1_NINE]}
                                        + 4'h1) begin
                            next_q.rx_sh = {maj3(cur), q.rx_sh[8:1]};
                        end else begin
                            rx_done         = 1'b1;
                            next_q.rx_st    = RX_IDLE;
                            next_q.idle_cnt = 8'h00;
                            if (q.c1[C1_PE]) begin
                                bad_par = (q.c1[C1_NINE] ? ^q.rx_sh
                                           : ^q.rx_sh[8:1])
                                          != q.c1[C1_PODD];
                            end
                            // same stop test for any break length
                            if (!stop && q.rx_sh != 9'h000) begin
                                next_q.rx_hist = 3'h7; // quick restart
                            end
                            // a pending framing fault blocks transfer
                            if (q.err[E_FE]) begin
                                next_q.err[E_FE] = next_q.err[E_FE];
                            end else if (q.receive_full_flag) begin
                                next_q.err[E_OR] = 1'b1;
                            end else begin
                                next_q.receive_full_flag   = 1'b1;
                                next_q.rx_buf = q.c1[C1_NINE]
                                                ? q.rx_sh[7:0]
                                                : q.rx_sh[8:1];
                                next_q.r8     = q.rx_sh[8];
                                next_q.err[E_NF] = next_q.rx_noise;
                                next_q.err[E_FE] = ~stop;
                                next_q.err[E_PF] = bad_par;
                            end
                        end
                    end
                    // realign on falling edges inside a frame
                    if (next_q.rx_st == RX_FRAME && q.rx_idx != 4'h0
                        && q.rx_hist[0] && !rx_pin) begin
                        next_q.rx_rt = RT_FIRST;
                        if (q.rx_rt >= RT_LATE) begin
                            next_q.rx_idx = q.rx_idx + 4'h1;
                        end
                    end
                end
                default: next_q.rx_st = RX_IDLE;
            endcase
        end

        // inverted drive covers idle, break and data
        next_q.tx_pin = next_q.tx_line ^ next_q.inv;
        // single-wire mode hands the pin to the direction bit
        next_q.oe = (next_q.c1[C1_LOOP_SELECT] && next_q.c1[C1_RECEIVER_SOURCE_SELECT])
                    ? next_q.dir
                    : (next_q.c1[C1_TE] || next_q.tx_st != TX_IDLE);
        // level request while an enabled flag stays set
        next_q.irq = |(next_q.err & next_q.ie);
        // answer comes one cycle after the request, read data frozen
        next_q.ack = req & ~q.ack;
        if (avs.read && !q.ack) begin
            next_q.rdata = rd_val;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= ST_RESET;
        end else begin
            q <= next_q;
        end
    end

    default clocking usc_cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_stat2_write_held: assert property ((acc && avs.write
        && avs.address == OFS_STAT2 && !tick) |=> $stable(q.receiver_active_flag))
        else $error("status_two write changed receiver_active_flag");
    a_break_line_low: assert property ((q.tx_st == TX_BREAK)
        |-> (txd_out == q.inv))
        else $error("break not driven as space");
    a_inv_pin: assert property (txd_out == (q.tx_line ^ q.inv))
        else $error("output polarity wrong");
    a_wire_dir: assert property ((q.c1[C1_LOOP_SELECT] && q.c1[C1_RECEIVER_SOURCE_SELECT])
        |-> (txd_oe == q.dir))
        else $error("single-wire direction not honoured");
    a_ovr_irq: assert property ((q.err[E_OR] && q.ie[E_OR])
        |-> irq_req)
        else $error("overrun request missing");
    a_noise_irq: assert property ((q.err[E_NF] && q.ie[E_NF])
        |-> irq_req)
        else $error("noise request missing");
    a_frame_irq: assert property ((q.err[E_FE] && q.ie[E_FE])
        |-> irq_req)
        else $error("framing request missing");
    a_par_irq: assert property ((q.err[E_PF] && q.ie[E_PF])
        |-> irq_req)
        else $error("parity request missing");
    a_irq_cause: assert property (irq_req |-> |(q.err & q.ie))
        else $error("request without enabled flag");
    a_tx_load: assert property ((acc && avs.write
        && avs.address == OFS_DATA)
        |=> (q.tx_full && q.tx_buf == $past(avs.writedata[7:0])
             && q.tx_buf8 == $past(q.t8)))
        else $error("transmit buffer not loaded");
    a_ninth_needed: assert property ((q.receive_full_flag && q.c1[C1_NINE]
        && !q.seen_c3 && !(acc && avs.read && avs.address == OFS_CTRL3))
        |=> q.receive_full_flag)
        else $error("receive_full_flag cleared without ninth-bit read");
    a_overrun_set: assert property ((rx_done && q.receive_full_flag && !q.err[E_FE])
        |=> (q.err[E_OR] && $stable(q.rx_buf)))
        else $error("overrun not flagged or data replaced");
    a_bus_answer: assert property ((req && avs_waitrequest)
        |=> !avs_waitrequest)
        else $error("bus answer late");

    c_break_sent: cover property (q.tx_st == TX_BREAK
        ##1 q.tx_st == TX_IDLE);
    c_overrun: cover property (rx_done && q.receive_full_flag);
    c_nine_clear: cover property (q.receive_full_flag && q.c1[C1_NINE] ##1 !q.receive_full_flag);
    c_resync: cover property (q.rx_st == RX_FRAME && q.rx_idx != 4'h0
        && q.rx_hist[0] && !rx_pin && tick);

endmodule // usc_core

`default_nettype wire

// ### usc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// remote transceiver: 8 data bits, no parity, one stop bit
module usc_far_end #(
    parameter int BIT = 16
) (
    input  wire logic       clk_sys,
    input  wire logic       line,
    input  wire logic       inv,
    output logic            rxd,
    output logic            got,
    output logic [7:0]      got_byte,
    output logic            brk_vld,
    output logic [4:0]      brk_bits
);
    int   lo_cnt = 0;
    logic lv;

    assign lv = line ^ inv;  // undo polarity so frames decode either way
    initial rxd = 1'b1;
    initial got = 1'b0;
    initial brk_vld = 1'b0;

    // frame out, LSB first, line idles high afterwards
    task automatic send(input logic [7:0] b);
        rxd <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge clk_sys);
    endtask

    // mid-bit sampling; short glitches are rejected at mid start
    initial forever begin
        @(posedge clk_sys);
        got <= 1'b0;
        if (lv === 1'b0) begin
            repeat (BIT / 2) @(posedge clk_sys);
            if (lv === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    got_byte[i] <= lv;
                end
                repeat (BIT) @(posedge clk_sys);
                got <= lv;  // a low stop bit is a break, not a byte
                while (lv !== 1'b1) @(posedge clk_sys);
            end
        end
    end

    // time each long low run to measure break length in bit times
    always @(posedge clk_sys) begin
        brk_vld <= 1'b0;
        if (lv === 1'b0)
            lo_cnt <= lo_cnt + 1;
        else begin
            if (lo_cnt >= 9 * BIT) begin
                brk_bits <= 5'((lo_cnt + BIT / 2) / BIT);
                brk_vld <= 1'b1;
            end
            lo_cnt <= 0;
        end
    end
endmodule // usc_far_end
`default_nettype wire

// ### usc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module usc_core_test;
    import usc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    usc_bus_t    avs = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        txd_out;
    logic        txd_oe;
    logic        irq_req;
    logic        rxd;
    logic        line_inv = 1'b0;
    logic        got;
    logic [7:0]  got_byte;
    logic        brk_vld;
    logic [4:0]  brk_bits;
    wire logic   txd_pin;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          seed = 32'hDD1F;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] seen_v;
    logic [7:0]  b1;
    logic [7:0]  b2;

    assign txd_pin = txd_oe ? txd_out : 1'b1;  // pulled up when released
    always #2 clk_sys = ~clk_sys;

    usc_core u_usc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs(avs),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rxd_in(rxd), .txd_in(txd_pin), .txd_out(txd_out), .txd_oe(txd_oe),
        .irq_req(irq_req));
    usc_far_end #(.BIT(16)) u_usc_far_end (.clk_sys(clk_sys), .line(txd_pin),
        .inv(line_inv), .rxd(rxd), .got(got), .got_byte(got_byte),
        .brk_vld(brk_vld), .brk_bits(brk_bits));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs <= '{read: !w, write: w, address: a, writedata: d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic tx(input logic [7:0] b);
        exp_q.push_back({24'h0, b});
        msk_q.push_back(32'hFF);
        bus(1'b1, OFS_DATA, {24'h0, b});
        @(posedge got);
    endtask

    // read data or a far-end byte retires the oldest note
    always @(negedge clk_sys) begin
        if ((avs.read && !avs_waitrequest) || got) begin
            seen_v = avs.read ? avs_readdata : {24'h0, got_byte};
            if (exp_q.size() == 0)
                chk(32'hFFFFFFFF, 32'h0);
            else
                chk(seen_v & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        rd(OFS_STAT2, 32'h0, 32'hFF);
        rd(5'h18, 32'h0, 32'hFFFFFFFF);        // unmapped reads zero
        bus(1'b1, OFS_STAT2, 32'hFF);
        rd(OFS_STAT2, 32'h04, 32'hFF);
        bus(1'b1, OFS_BAUD, 32'h1);
        bus(1'b1, OFS_CTRL1, 32'h18);
        $display("test regs done");
        tx(b1);
        bus(1'b1, OFS_CTRL3, 32'h10);
        line_inv <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({31'h0, txd_out}, 32'h0);
        tx(b2);
        repeat (32) @(posedge clk_sys);
        bus(1'b1, OFS_CTRL3, 32'h0);
        line_inv <= 1'b0;
        $display("test transmit done");
        fork
            u_usc_far_end.send(b1);
            begin
                repeat (64) @(posedge clk_sys);
                rd(OFS_STAT2, 32'h1, 32'h1);
            end
        join
        repeat (192) @(posedge clk_sys);       // idle detect takes 10 bits
        rd(OFS_STAT2, 32'h0, 32'h1);
        rd(OFS_PSTAT, 32'h20, 32'h20);
        rd(OFS_DATA, {24'h0, b1}, 32'hFF);
        rd(OFS_PSTAT, 32'h0, 32'h20);
        u_usc_far_end.send(b1);
        u_usc_far_end.send(b2);
        chk({31'h0, irq_req}, 32'h0);
        bus(1'b1, OFS_CTRL3, 32'h8);
        repeat (4) @(negedge clk_sys);
        chk({31'h0, irq_req}, 32'h1);
        rd(OFS_PSTAT, 32'h28, 32'h28);
        rd(OFS_DATA, {24'h0, b1}, 32'hFF);
        repeat (4) @(negedge clk_sys);
        chk({31'h0, irq_req}, 32'h0);
        $display("test receive done");
        // nine-bit loop: ninth bit travels out and back, both reads clear
        bus(1'b1, OFS_CTRL3, 32'h40);
        bus(1'b1, OFS_CTRL1, 32'h1B);
        tx(b2);
        repeat (48) @(posedge clk_sys);
        rd(OFS_PSTAT, 32'h20, 32'h20);
        rd(OFS_DATA, {24'h0, b2}, 32'hFF);
        rd(OFS_PSTAT, 32'h20, 32'h20);
        rd(OFS_DATA, {24'h0, b2}, 32'hFF);
        rd(OFS_CTRL3, 32'hC0, 32'hC0);
        rd(OFS_PSTAT, 32'h0, 32'h20);
        $display("test nine bit done");
        // looped breaks: short and long select, framing fault either way
        bus(1'b1, OFS_CTRL3, 32'h2);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFS_STAT2, 32'(k) << 2);
            bus(1'b1, OFS_CTRL1, 32'h3A);
            bus(1'b1, OFS_CTRL1, 32'h1A);
            @(posedge brk_vld);
            chk(32'(brk_bits), (k == 1) ? 32'hD : 32'hA);
            repeat (4) @(negedge clk_sys);
            chk({31'h0, irq_req}, 32'h1);
            rd(OFS_PSTAT, 32'h02, 32'h02);
            rd(OFS_DATA, 32'h0, 32'hFF);
            repeat (4) @(negedge clk_sys);
            chk({31'h0, irq_req}, 32'h0);
        end
        $display("test break done");
        bus(1'b1, OFS_CTRL1, 32'h1E);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFS_CTRL3, 32'(k) << 5);
            repeat (4) @(negedge clk_sys);
            chk({31'h0, txd_oe}, 32'(k));
        end
        $display("test single wire done");
        summarize();
    end
endmodule // usc_core_test
`default_nettype wire
